// [ctk_pkg.sv]
/*
 * ctk_pkg: constants, register map and carrier types of the clock tick counter.
 * assumes a 200 MHz system clock and a 16-bit i/o address space with 4-bit data.
 */
package ctk_pkg;

    // ==========================================================
    // bus geometry
    // ==========================================================
    localparam int ADDR_W = 16;
    localparam int DATA_W = 4;
    localparam int CNT_W  = 8;
    localparam int FLAG_W = 4;

    // ==========================================================
    // register offsets
    // ==========================================================
    localparam logic [15:0] OFS_RUN_CLR  = 16'hff78;
    localparam logic [15:0] OFS_CNT_LO   = 16'hff79;
    localparam logic [15:0] OFS_CNT_HI   = 16'hff7a;
    localparam logic [15:0] OFS_IRQ_EN   = 16'hffe6;
    localparam logic [15:0] OFS_IRQ_FLAG = 16'hfff6;

    // ==========================================================
    // field positions and reset values
    // ==========================================================
    localparam int BIT_RUN   = 0;
    localparam int BIT_CLEAR = 1;
    localparam int TAP16_BIT = 3;
    localparam int TAP8_BIT  = 4;
    localparam int TAP2_BIT  = 6;
    localparam int TAP1_BIT  = 7;

    localparam logic [7:0] CNT_RST   = 8'h00;
    localparam logic [3:0] EN_RST    = 4'h0;
    localparam logic [3:0] FLAG_RST  = 4'h0;
    localparam logic       RUN_RST   = 1'b0;
    localparam logic [3:0] DATA_ZERO = 4'h0;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int CLK_PERIOD_PS = 5000;
    localparam int HOLD_TIME_US  = 1000;
    localparam int HOLD_CYCLES   = (HOLD_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int HOLD_CNT_W    = 18;

    // ==========================================================
    // carrier types
    // ==========================================================
    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ctk_bus_req_t;

    typedef struct packed {
        logic [CNT_W-1:0]  count;
        logic [FLAG_W-1:0] flags;
    } ctk_state_t;

    function automatic logic ctk_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

endpackage

// [ctk_sync.sv]
/*
 * ctk_sync: three-stage synchroniser with agreement filter and rising-edge pulse.
 * assumes the input is a slow level from another clock domain.
 */
`timescale 1ns/1ps
module ctk_sync
    import ctk_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // pin side
    input  wire logic async_in,
    // system side
    output logic      rise_pulse_r
);

    logic stage1_r;
    logic stage2_r;
    logic stage3_r;
    logic level_r;

    // ==========================================================
    // synchroniser chain
    // ==========================================================
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stage1_r <= 1'b0;
            stage2_r <= 1'b0;
            stage3_r <= 1'b0;
        end else begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // ==========================================================
    // filtered level and edge
    // ==========================================================
    // a change only counts once stages two and three agree
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            level_r      <= 1'b0;
            rise_pulse_r <= 1'b0;
        end else begin
            rise_pulse_r <= 1'b0;
            if (stage2_r == stage3_r) begin
                level_r      <= stage3_r;
                rise_pulse_r <= stage3_r & ~level_r;
            end
        end
    end

endmodule

// [ctk_hold.sv]
/*
 * ctk_hold: hold window for the upper count nibble.
 * assumes start and stop are one-cycle pulses in the system clock domain.
 */
`timescale 1ns/1ps
module ctk_hold
    import ctk_pkg::*;
#(
    parameter logic [HOLD_CNT_W-1:0] HOLD_CYC = HOLD_CNT_W'(HOLD_CYCLES)
)
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset,
    // control
    input  wire logic start,
    input  wire logic stop,
    // status
    output logic      hold_r
);

    typedef enum logic [0:0] {
        HS_IDLE = 1'b0,
        HS_HOLD = 1'b1
    } ctk_hold_state_t;

    ctk_hold_state_t              state_r;
    logic [HOLD_CNT_W-1:0]        left_r;

    // ==========================================================
    // window state
    // ==========================================================
    // a fresh low read restarts the window; a high read ends it
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r <= HS_IDLE;
            left_r  <= '0;
            hold_r  <= 1'b0;
        end else begin
            unique case (state_r)
                HS_IDLE: begin
                    if (start) begin
                        state_r <= HS_HOLD;
                        left_r  <= HOLD_CYC;
                        hold_r  <= 1'b1;
                    end
                end
                HS_HOLD: begin
                    if (start) begin
                        left_r <= HOLD_CYC;
                    end else if (stop || left_r <= HOLD_CNT_W'(1)) begin
                        state_r <= HS_IDLE;
                        hold_r  <= 1'b0;
                    end else begin
                        left_r <= left_r - HOLD_CNT_W'(1);
                    end
                end
            endcase
        end
    end

endmodule

// [ctk_top.sv]
/*
 * ctk_top: clock tick counter with run/clear control, split count read-out,
 * upper-nibble hold, four tap interrupts with enables and an interrupt request.
 * assumes a 256 Hz prescaler tap arriving asynchronously, and a cpu-side
 * register port with one-cycle strobes and read data one cycle later.
 * the hold length is a parameter so a bench can shorten the window;
 * a carry that meets an open window is parked, never dropped.
 */
`timescale 1ns/1ps
module ctk_top
    import ctk_pkg::*;
#(
    parameter logic [HOLD_CNT_W-1:0] HOLD_CYC = HOLD_CNT_W'(HOLD_CYCLES)
)
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset,
    // prescaler tap, 256 Hz, asynchronous
    input  wire logic              prescale_tick_in,
    // register port
    input  wire ctk_bus_req_t      bus_req,
    output logic [DATA_W-1:0]      rd_data_r,
    // interrupt and status
    output logic                   irq_r,
    output logic [CNT_W-1:0]       tick_count_bits_r
);

    // ==========================================================
    // declarations
    // ==========================================================
    logic                tick_pulse;
    logic                hold_active;
    logic                run_control_bit_r;
    logic [FLAG_W-1:0]   irq_enable_r;
    logic [FLAG_W-1:0]   irq_flag_r;
    logic                carry_pending_r;

    logic [CNT_W-1:0]    count_nxt;
    logic                carry_pending_nxt;
    logic [FLAG_W-1:0]   tap_fall;
    logic [FLAG_W-1:0]   irq_flag_nxt;
    logic [DATA_W-1:0]   rd_data_nxt;
    logic [3:0]          hi_nxt;
    logic [FLAG_W-1:0]   irq_enable_nxt;
    logic [FLAG_W-1:0]   irq_pairs;
    logic                irq_nxt;

    logic                wr_run_clr;
    logic                wr_enable;
    logic                wr_flag;
    logic                rd_cnt_lo;
    logic                rd_cnt_hi;
    logic                counter_clear;
    logic [3:0]          lo_nib;
    logic [3:0]          hi_nib;
    logic [3:0]          lo_inc;
    logic                lo_carry;
    ctk_state_t          snap;

    // ==========================================================
    // helpers
    // ==========================================================
    // one step of a count nibble; wraps from f to 0
    function automatic logic [3:0] nib_step(input logic [3:0] nib);
        return nib + 4'h1;
    endfunction

    // a tap falls when its bit is set now and clear in the next value
    function automatic logic tap_drop(input logic [CNT_W-1:0] now_v,
                                      input logic [CNT_W-1:0] next_v,
                                      input int               pos);
        return now_v[pos] & ~next_v[pos];
    endfunction

    // ==========================================================
    // prescaler tap input
    // ==========================================================
    ctk_sync u_sync (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .async_in     (prescale_tick_in),
        .rise_pulse_r (tick_pulse)
    );

    // ==========================================================
    // access decode
    // ==========================================================
    assign wr_run_clr = bus_req.wr && ctk_hit(bus_req.addr, OFS_RUN_CLR);
    assign wr_enable  = bus_req.wr && ctk_hit(bus_req.addr, OFS_IRQ_EN);
    assign wr_flag    = bus_req.wr && ctk_hit(bus_req.addr, OFS_IRQ_FLAG);
    assign rd_cnt_lo  = bus_req.rd && ctk_hit(bus_req.addr, OFS_CNT_LO);
    assign rd_cnt_hi  = bus_req.rd && ctk_hit(bus_req.addr, OFS_CNT_HI);

    // writes of zero to the clear bit do nothing
    assign counter_clear = wr_run_clr && bus_req.wdata[BIT_CLEAR];

    // ==========================================================
    // upper nibble hold window
    // ==========================================================
    // only a low read opens the window, so a high-first read sees no hold
    ctk_hold #(
        .HOLD_CYC (HOLD_CYC)
    ) u_hold (
        .sys_clk (sys_clk),
        .reset   (reset),
        .start   (rd_cnt_lo),
        .stop    (rd_cnt_hi),
        .hold_r  (hold_active)
    );

    // ==========================================================
    // counter next value
    // ==========================================================
    assign lo_nib   = tick_count_bits_r[3:0];
    assign hi_nib   = tick_count_bits_r[7:4];
    assign lo_inc   = nib_step(lo_nib);
    assign lo_carry = (lo_nib == 4'hf);

    // a carry arriving during the hold is parked and applied when the
    // window closes, so the upper nibble never loses a step
    always_comb begin
        count_nxt         = tick_count_bits_r;
        carry_pending_nxt = carry_pending_r;
        hi_nxt            = hi_nib;
        if (counter_clear) begin
            count_nxt         = CNT_RST;
            carry_pending_nxt = 1'b0;
        end else begin
            if (run_control_bit_r && tick_pulse) begin
                count_nxt[3:0] = lo_inc;
                if (lo_carry) begin
                    if (hold_active) begin
                        carry_pending_nxt = 1'b1;
                    end else begin
                        hi_nxt = nib_step(hi_nxt);
                    end
                end
            end
            // a parked carry and a fresh one in the same cycle both land
            if (!hold_active && carry_pending_r) begin
                hi_nxt            = nib_step(hi_nxt);
                carry_pending_nxt = 1'b0;
            end
            count_nxt[7:4] = hi_nxt;
        end
    end

    // ==========================================================
    // count register
    // ==========================================================
    // writes to the data addresses are never decoded here
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tick_count_bits_r <= CNT_RST;
        end else begin
            tick_count_bits_r <= count_nxt;
        end
    end

    // ==========================================================
    // parked carry
    // ==========================================================
    // one waiting carry is enough: a window is far shorter than a
    // full turn of the low nibble
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            carry_pending_r <= 1'b0;
        end else begin
            carry_pending_r <= carry_pending_nxt;
        end
    end

    // ==========================================================
    // run control
    // ==========================================================
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            run_control_bit_r <= RUN_RST;
        end else if (wr_run_clr) begin
            run_control_bit_r <= bus_req.wdata[BIT_RUN];
        end
    end

    // ==========================================================
    // tap falling edges
    // ==========================================================
    // taken from the register and its next value, so a clear that
    // drops a tap bit also counts as that tap falling
    always_comb begin
        tap_fall[0] = tap_drop(tick_count_bits_r, count_nxt, TAP16_BIT);
        tap_fall[1] = tap_drop(tick_count_bits_r, count_nxt, TAP8_BIT);
        tap_fall[2] = tap_drop(tick_count_bits_r, count_nxt, TAP2_BIT);
        tap_fall[3] = tap_drop(tick_count_bits_r, count_nxt, TAP1_BIT);
    end

    // ==========================================================
    // interrupt enables
    // ==========================================================
    // a write lands in the register and in the request on the same edge
    assign irq_enable_nxt = wr_enable ? bus_req.wdata : irq_enable_r;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_enable_r <= EN_RST;
        end else if (wr_enable) begin
            irq_enable_r <= bus_req.wdata;
        end
    end

    // ==========================================================
    // interrupt flags
    // ==========================================================
    // an edge in the same cycle as a write-one clear keeps the flag set
    always_comb begin
        irq_flag_nxt = irq_flag_r;
        if (wr_flag) begin
            irq_flag_nxt = irq_flag_nxt & ~bus_req.wdata;
        end
        irq_flag_nxt = irq_flag_nxt | tap_fall;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_flag_r <= FLAG_RST;
        end else begin
            irq_flag_r <= irq_flag_nxt;
        end
    end

    // ==========================================================
    // interrupt request
    // ==========================================================
    // follows the next flag and enable values so it stays aligned with
    // the registers software can read back
    assign irq_pairs = irq_flag_nxt & irq_enable_nxt;
    assign irq_nxt   = |irq_pairs;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // ==========================================================
    // read data
    // ==========================================================
    // snapshot of the live state; unmapped addresses read zero
    assign snap.count = tick_count_bits_r;
    assign snap.flags = irq_flag_r;

    always_comb begin
        rd_data_nxt = DATA_ZERO;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                OFS_RUN_CLR: begin
                    // the clear bit always reads zero
                    rd_data_nxt          = DATA_ZERO;
                    rd_data_nxt[BIT_RUN] = run_control_bit_r;
                end
                OFS_CNT_LO: begin
                    rd_data_nxt = snap.count[3:0];
                end
                OFS_CNT_HI: begin
                    rd_data_nxt = snap.count[7:4];
                end
                OFS_IRQ_EN: begin
                    rd_data_nxt = irq_enable_r;
                end
                OFS_IRQ_FLAG: begin
                    rd_data_nxt = snap.flags;
                end
                default: begin
                    rd_data_nxt = DATA_ZERO;
                end
            endcase
        end
    end

    // read data stand for exactly one cycle after the strobe
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_data_r <= DATA_ZERO;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

endmodule

// [ctk_tap_src.sv]
/*
 * ctk_tap_src: prescaler tap source, one slow rising edge per fire request.
 * assumes fire is a one-cycle request; busy stays high until six clocks after the tap is low again.
 */
`timescale 1ns/1ps
module ctk_tap_src
(
    // clock
    input  wire logic sys_clk,
    // request and tap
    input  wire logic fire,
    output logic      tap,
    output logic      busy
);
    // ==========================================================
    // one tap period
    // ==========================================================
    // one process owns both outputs; odd offsets keep the tap edges
    // away from the clock edges
    initial begin
        tap  = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge fire);
            busy = 1'b1;
            #1.7 tap = 1'b1;
            repeat (6) @(posedge sys_clk);
            #2.1 tap = 1'b0;
            repeat (6) @(posedge sys_clk);
            busy = 1'b0;
        end
    end
endmodule

// [ctk_top_assertions.sv]
/*
 * ctk_checker: port-level checks of the clock tick counter.
 * assumes it is bound onto ctk_top, one clock domain.
 */
`timescale 1ns/1ps
module ctk_checker
    import ctk_pkg::*;
#(
    parameter logic [HOLD_CNT_W-1:0] HOLD_CYC = HOLD_CNT_W'(HOLD_CYCLES)
)
(
    // clock and reset
    input wire logic         sys_clk,
    input wire logic         reset,
    // watched ports
    input wire logic         prescale_tick_in,
    input wire ctk_bus_req_t bus_req,
    input wire logic [3:0]   rd_data_r,
    input wire logic         irq_r,
    input wire logic [7:0]   tick_count_bits_r
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic rd_lo;
    logic rd_hi;
    logic rd_ctl;
    logic wr_ctl;
    logic wr_en;
    assign rd_lo  = bus_req.rd && bus_req.addr == OFS_CNT_LO;
    assign rd_hi  = bus_req.rd && bus_req.addr == OFS_CNT_HI;
    assign rd_ctl = bus_req.rd && bus_req.addr == OFS_RUN_CLR;
    assign wr_ctl = bus_req.wr && bus_req.addr == OFS_RUN_CLR;
    assign wr_en  = bus_req.wr && bus_req.addr == OFS_IRQ_EN;

    // ==========================================================
    // assertions
    // ==========================================================
    rd_idle_a: assert property (!$past(bus_req.rd) |-> rd_data_r == 4'h0)
        else $error("read data not zero outside a read");
    cnt_lo_rd_a: assert property ($past(rd_lo) |-> rd_data_r == $past(tick_count_bits_r[3:0]))
        else $error("low nibble read wrong");
    cnt_hi_rd_a: assert property ($past(rd_hi) |-> rd_data_r == $past(tick_count_bits_r[7:4]))
        else $error("high nibble read wrong");
    ctl_read_a: assert property ($past(rd_ctl) |-> rd_data_r[3:1] == 3'h0)
        else $error("clear bit read nonzero");
    cnt_step_a: assert property (tick_count_bits_r != $past(tick_count_bits_r) |->
        (tick_count_bits_r - $past(tick_count_bits_r)) inside {8'h01, 8'h10, 8'h11, 8'hf1}
        || tick_count_bits_r == 8'h00)
        else $error("count moved by an illegal step");
    clr_now_a: assert property (wr_ctl && bus_req.wdata[BIT_CLEAR] |=> tick_count_bits_r == 8'h00)
        else $error("clear did not zero the count");
    irq_mask_a: assert property (wr_en && bus_req.wdata == 4'h0 |=> !irq_r)
        else $error("request high with all enables off");
    irq_cause_a: assert property ($rose(irq_r) |-> $past(wr_en)
        || tick_count_bits_r != $past(tick_count_bits_r))
        else $error("request rose without a cause");
    rst_zero_a: assert property ($fell(reset) |-> tick_count_bits_r == 8'h00 && !irq_r)
        else $error("state not zero after reset");

    // ==========================================================
    // covers
    // ==========================================================
    cover property (rd_lo ##[1:40] rd_hi);
    cover property (wr_ctl && bus_req.wdata[BIT_CLEAR]);
    cover property ($rose(irq_r));
endmodule

bind ctk_top ctk_checker #(.HOLD_CYC(HOLD_CYC)) chk_u (.sys_clk(sys_clk), .reset(reset),
    .prescale_tick_in(prescale_tick_in), .bus_req(bus_req), .rd_data_r(rd_data_r), .irq_r(irq_r),
    .tick_count_bits_r(tick_count_bits_r));

// [ctk_top_bench.sv]
/*
 * ctk_top_bench: self-checking bench of the clock tick counter.
 * assumes ctk_top, the tap source model and the bound checker.
 */
`timescale 1ns/1ps
module ctk_top_bench
    import ctk_pkg::*;
;
    localparam int HOLD_SIM = 40;

    logic         sys_clk;
    logic         reset;
    logic         tap;
    logic         fire;
    logic         busy;
    logic         irq_r;
    ctk_bus_req_t bus_req;
    logic [3:0]   rd_data_r;
    logic [7:0]   count;
    int           fails;
    int           checks;

    // short hold window keeps the timeout case quick
    ctk_top #(.HOLD_CYC(18'(HOLD_SIM))) dut_u (.sys_clk(sys_clk), .reset(reset), .prescale_tick_in(tap),
        .bus_req(bus_req), .rd_data_r(rd_data_r), .irq_r(irq_r), .tick_count_bits_r(count));
    ctk_tap_src tap_u (.sys_clk(sys_clk), .fire(fire), .tap(tap), .busy(busy));

    always #2.5 sys_clk = ~sys_clk;

    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [3:0] v);
        @(posedge sys_clk);
        bus_req.wr <= 1'b1;
        bus_req.addr <= a;
        bus_req.wdata <= v;
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [3:0] exp);
        @(posedge sys_clk);
        bus_req.rd <= 1'b1;
        bus_req.addr <= a;
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk(8'(rd_data_r), 8'(exp));
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            fire <= 1'b1;
            @(posedge sys_clk);
            fire <= 1'b0;
            @(posedge sys_clk);
            for (int k = 0; k < 40 && busy; k++) @(posedge sys_clk);
        end
    endtask

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic t_reset();
        chk(count, 8'h00);
        chk(8'(irq_r), 8'h00);
        rd_chk(OFS_RUN_CLR, 4'h0);
        rd_chk(OFS_CNT_LO, 4'h0);
        rd_chk(OFS_CNT_HI, 4'h0);
        rd_chk(OFS_IRQ_EN, 4'h0);
        rd_chk(OFS_IRQ_FLAG, 4'h0);
        rd_chk(16'hff7b, 4'h0);
    endtask

    task automatic t_count_flags();
        wr(OFS_RUN_CLR, 4'h1);
        tick(16);
        chk(count, 8'h10);
        rd_chk(OFS_CNT_LO, 4'h0);
        rd_chk(OFS_CNT_HI, 4'h1);
        rd_chk(OFS_IRQ_FLAG, 4'h1);
        chk(8'(irq_r), 8'h00);
        wr(OFS_IRQ_EN, 4'h1);
        chk(8'(irq_r), 8'h01);
        wr(OFS_IRQ_FLAG, 4'h0);
        rd_chk(OFS_IRQ_FLAG, 4'h1);
        wr(OFS_IRQ_FLAG, 4'h1);
        rd_chk(OFS_IRQ_FLAG, 4'h0);
        chk(8'(irq_r), 8'h00);
        wr(OFS_CNT_LO, 4'hf);
        wr(OFS_CNT_HI, 4'hf);
        chk(count, 8'h10);
        tick(240);
        chk(count, 8'h00);
        rd_chk(OFS_IRQ_FLAG, 4'hf);
        chk(8'(irq_r), 8'h01);
        wr(OFS_IRQ_EN, 4'ha);
        rd_chk(OFS_IRQ_EN, 4'ha);
        chk(8'(irq_r), 8'h01);
        wr(OFS_IRQ_FLAG, 4'ha);
        chk(8'(irq_r), 8'h00);
        rd_chk(OFS_IRQ_FLAG, 4'h5);
        wr(OFS_IRQ_FLAG, 4'hf);
        wr(OFS_IRQ_EN, 4'h0);
    endtask

    task automatic t_hold();
        tick(15);
        rd_chk(OFS_CNT_LO, 4'hf);
        tick(1);
        rd_chk(OFS_CNT_HI, 4'h0);
        rd_chk(OFS_CNT_HI, 4'h1);
        tick(15);
        rd_chk(OFS_CNT_LO, 4'hf);
        tick(1);
        repeat (HOLD_SIM + 5) @(posedge sys_clk);
        rd_chk(OFS_CNT_HI, 4'h2);
    endtask

    task automatic t_clear();
        wr(OFS_RUN_CLR, 4'h3);
        chk(count, 8'h00);
        tick(3);
        chk(count, 8'h03);
        rd_chk(OFS_RUN_CLR, 4'h1);
        wr(OFS_RUN_CLR, 4'h0);
        tick(2);
        chk(count, 8'h03);
        rd_chk(OFS_RUN_CLR, 4'h0);
        wr(OFS_RUN_CLR, 4'h2);
        tick(1);
        chk(count, 8'h00);
        wr(OFS_RUN_CLR, 4'h1);
        tick(1);
        chk(count, 8'h01);
    endtask

    // ==========================================================
    // main sequence and watchdog
    // ==========================================================
    initial begin
        sys_clk = 1'b0;
        reset = 1'b1;
        fire = 1'b0;
        bus_req = '0;
        fails = 0;
        checks = 0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_count_flags();
        t_hold();
        t_clear();
        test_done();
    end

    // about 3800 cycles expected; generous margin
    initial begin
        #200000;
        fails++;
        test_done();
    end
endmodule
